// ==== hdl/lsd_pkg.sv ====
// Purpose: Shared constants, register offsets and carriers of the logic slice
// Assumes: Plain register port with 32-bit data and word offsets
// Notes: Configuration layout is the packed struct lsd_cfg_t, bit 0 last
package lsd_pkg;
	localparam int unsigned LSD_AW        = 4;
	localparam int unsigned LSD_DW        = 32;
	localparam int unsigned LSD_LUT_BITS  = 16;
	localparam int unsigned LSD_LUT_AW    = 4;
	localparam int unsigned LSD_GEN_IDX   = 0;
	localparam int unsigned LSD_DONE_BIT  = 0;

	localparam logic [LSD_AW-1:0] LSD_OFS_LUT_LO = 4'h0;
	localparam logic [LSD_AW-1:0] LSD_OFS_LUT_HI = 4'h1;
	localparam logic [LSD_AW-1:0] LSD_OFS_CFG    = 4'h2;
	localparam logic [LSD_AW-1:0] LSD_OFS_CTRL   = 4'h3;
	localparam logic [LSD_AW-1:0] LSD_OFS_STAT   = 4'h4;

	localparam logic [1:0] LSD_MODE_LOGIC = 2'h0;
	localparam logic [1:0] LSD_MODE_RAM   = 2'h1;
	localparam logic [1:0] LSD_MODE_SHIFT = 2'h2;

	localparam logic [1:0] LSD_OUT_LUT  = 2'h0;
	localparam logic [1:0] LSD_OUT_SUM  = 2'h1;
	localparam logic [1:0] LSD_OUT_WIDE = 2'h2;

	typedef struct packed {
		logic [10:0] rsvd;
		logic [1:0]  mode_hi;
		logic [1:0]  mode_lo;
		logic [1:0]  out_sel_hi;
		logic [1:0]  out_sel_lo;
		logic        gen_byp_hi;
		logic        gen_byp_lo;
		logic        d_byp_hi;
		logic        d_byp_lo;
		logic        aux_en;
		logic        opp_en;
		logic        init_hi;
		logic        init_lo;
		logic        byp_hi_inv;
		logic        byp_lo_inv;
		logic        setrst_inv;
		logic        ce_inv;
		logic        clk_inv;
	} lsd_cfg_t;

	typedef struct packed {
		logic [3:0] lower_lut_input;
		logic [3:0] upper_lut_input;
		logic       lower_bypass_in;
		logic       upper_bypass_in;
		logic       carry_in;
		logic       wide_in;
		logic       slice_clk;
		logic       slice_ce;
		logic       flop_set_reset;
		logic       lut_write_en;
		logic       global_init;
	} lsd_in_t;

	typedef struct packed {
		logic lower_comb_out;
		logic upper_comb_out;
		logic lower_flop_out;
		logic upper_flop_out;
		logic lower_carry_or_shift_out;
		logic upper_carry_or_shift_out;
		logic lower_bypass_out;
		logic upper_bypass_out;
		logic aux_route_out;
		logic carry_out;
	} lsd_out_t;

	typedef struct packed {
		lsd_in_t                 sync1;
		lsd_in_t                 sync2;
		logic                    clk_prev;
		logic [LSD_LUT_BITS-1:0] lut_lo;
		logic [LSD_LUT_BITS-1:0] lut_hi;
		lsd_cfg_t                cfg;
		logic                    cfg_done;
		lsd_out_t                pins;
		logic [LSD_DW-1:0]       rdata;
	} lsd_st_t;

	localparam lsd_st_t LSD_ST_RST = '0;
endpackage

// ==== hdl/lsd_slice.sv ====
// Purpose: One configurable logic slice with two halves, carry and wide selectors
// Assumes: Interconnect inputs are asynchronous to clk_sys; slice clock is sampled
// Notes: Every output is registered, three clk_sys edges behind its pin inputs
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps

// Contract
// - Four interconnect lines per half address that half's table directly.
// - Each table gives any programmed Boolean function of four inputs.
// - Table output may leave unregistered on the half's combinational output.
// - Combinational result is selectable as flop data; flop drives registered output.
// - Table output selects between incoming carry and generated value.
// - Table output XOR incoming carry gives the sum on combinational output.
// - Both table outputs feed the lower pair selector for wide functions.
// - Each bypass input drives its half's wide selector select.
// - Bypass input goes straight to its dedicated bypass output.
// - Bypass input may load the flop directly, skipping the table.
// - Bypass input is selectable as carry chain operand.
// - Bypass input is the table write data in memory modes.
// - Upper bypass may force both flops to their opposite state.
// - Selector may switch upper bypass onto the auxiliary route output.
// - Clock, enable, set/reset and both bypasses have polarity options.
// - Memory-capable slice tables work as RAM or 16-bit shift register.
// - Auxiliary outputs carry carry result or the shift register serial out.
// - While global init is high all flops take their initial state.
// - Global init is held automatically throughout configuration.
module lsd_slice
	import lsd_pkg::*;
#(
	parameter bit MEM_CAPABLE = 1'b1
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [LSD_AW-1:0] reg_addr,
	input  wire logic [LSD_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output      logic [LSD_DW-1:0] reg_rdata,
	input  wire lsd_in_t           pins_in,
	output      lsd_out_t          pins_out
);

	lsd_st_t              st_reg;
	lsd_st_t              st_next;
	lsd_in_t              s;
	lsd_cfg_t             c;
	logic                 clk_lvl;
	logic                 clk_edge;
	logic                 ce_on;
	logic                 setrst_on;
	logic                 byp_lo;
	logic                 byp_hi;
	logic                 init_on;
	logic                 opp_on;
	logic                 cap;
	logic                 lut_lo_val;
	logic                 lut_hi_val;
	logic                 sum_lo;
	logic                 sum_hi;
	logic                 gen_lo;
	logic                 gen_hi;
	logic                 cy_lo;
	logic                 cy_hi;
	logic                 pair_out;
	logic                 wide_out;
	logic                 comb_lo;
	logic                 comb_hi;
	logic                 d_lo;
	logic                 d_hi;
	logic                 shift_lo;
	logic                 shift_hi;
	logic                 ram_lo;
	logic                 ram_hi;

	assign s = st_reg.sync2;
	assign c = st_reg.cfg;

	// Slice clock is a pin, so its edge is found after the synchroniser
	assign clk_lvl   = s.slice_clk ^ c.clk_inv;
	assign clk_edge  = clk_lvl & ~st_reg.clk_prev;
	assign ce_on     = s.slice_ce ^ c.ce_inv;
	assign setrst_on = s.flop_set_reset ^ c.setrst_inv;
	assign byp_lo    = s.lower_bypass_in ^ c.byp_lo_inv;
	assign byp_hi    = s.upper_bypass_in ^ c.byp_hi_inv;

	// Configuration counts as running until software sets the done bit
	assign init_on = s.global_init | ~st_reg.cfg_done;
	assign opp_on  = c.opp_en & byp_hi;
	assign cap     = clk_edge & ce_on;

	// No polarity option on table inputs: contents absorb inversion
	assign lut_lo_val = st_reg.lut_lo[s.lower_lut_input];
	assign lut_hi_val = st_reg.lut_hi[s.upper_lut_input];

	assign gen_lo = c.gen_byp_lo ? byp_lo : s.lower_lut_input[LSD_GEN_IDX];
	assign gen_hi = c.gen_byp_hi ? byp_hi : s.upper_lut_input[LSD_GEN_IDX];
	assign cy_lo  = lut_lo_val ? s.carry_in : gen_lo;
	assign cy_hi  = lut_hi_val ? cy_lo : gen_hi;
	assign sum_lo = lut_lo_val ^ s.carry_in;
	assign sum_hi = lut_hi_val ^ cy_lo;

	assign pair_out = byp_lo ? lut_hi_val : lut_lo_val;
	assign wide_out = byp_hi ? s.wide_in : pair_out;

	always_comb begin
		case (c.out_sel_lo)
			LSD_OUT_SUM:  comb_lo = sum_lo;
			LSD_OUT_WIDE: comb_lo = pair_out;
			default:      comb_lo = lut_lo_val;
		endcase
		case (c.out_sel_hi)
			LSD_OUT_SUM:  comb_hi = sum_hi;
			LSD_OUT_WIDE: comb_hi = wide_out;
			default:      comb_hi = lut_hi_val;
		endcase
	end

	assign d_lo = c.d_byp_lo ? byp_lo : comb_lo;
	assign d_hi = c.d_byp_hi ? byp_hi : comb_hi;

	// A logic-only build never enters the memory modes
	assign shift_lo = MEM_CAPABLE && (c.mode_lo == LSD_MODE_SHIFT);
	assign shift_hi = MEM_CAPABLE && (c.mode_hi == LSD_MODE_SHIFT);
	assign ram_lo   = MEM_CAPABLE && (c.mode_lo == LSD_MODE_RAM);
	assign ram_hi   = MEM_CAPABLE && (c.mode_hi == LSD_MODE_RAM);

	function automatic logic lsd_flop(
		input logic cur,
		input logic iv,
		input logic d
	);
		if (init_on || setrst_on) begin
			return iv;
		end
		if (opp_on) begin
			return ~iv;
		end
		if (cap) begin
			return d;
		end
		return cur;
	endfunction

	function automatic logic [LSD_LUT_BITS-1:0] lsd_lut(
		input logic [LSD_LUT_BITS-1:0] tab,
		input logic                    ram,
		input logic                    shf,
		input logic [LSD_LUT_AW-1:0]   addr,
		input logic                    din
	);
		logic [LSD_LUT_BITS-1:0] t;
		t = tab;
		if (ram && clk_edge && s.lut_write_en) begin
			t[addr] = din;
		end else if (shf && cap) begin
			t = {tab[LSD_LUT_BITS-2:0], din};
		end
		return t;
	endfunction

	always_comb begin
		st_next          = st_reg;
		st_next.sync1    = pins_in;
		st_next.sync2    = st_reg.sync1;
		st_next.clk_prev = clk_lvl;

		st_next.lut_lo = lsd_lut(st_reg.lut_lo, ram_lo, shift_lo, s.lower_lut_input, byp_lo);
		st_next.lut_hi = lsd_lut(st_reg.lut_hi, ram_hi, shift_hi, s.upper_lut_input, byp_hi);

		st_next.pins.lower_flop_out = lsd_flop(st_reg.pins.lower_flop_out, c.init_lo, d_lo);
		st_next.pins.upper_flop_out = lsd_flop(st_reg.pins.upper_flop_out, c.init_hi, d_hi);
		st_next.pins.lower_comb_out = comb_lo;
		st_next.pins.upper_comb_out = comb_hi;
		st_next.pins.lower_carry_or_shift_out =
			shift_lo ? st_reg.lut_lo[LSD_LUT_BITS-1] : cy_lo;
		st_next.pins.upper_carry_or_shift_out =
			shift_hi ? st_reg.lut_hi[LSD_LUT_BITS-1] : cy_hi;
		st_next.pins.lower_bypass_out = byp_lo;
		st_next.pins.upper_bypass_out = byp_hi;
		st_next.pins.aux_route_out    = c.aux_en & byp_hi;
		st_next.pins.carry_out        = cy_hi;

		// Software writes win over a memory-mode write in the same cycle
		if (reg_wr) begin
			case (reg_addr)
				LSD_OFS_LUT_LO: st_next.lut_lo = reg_wdata[LSD_LUT_BITS-1:0];
				LSD_OFS_LUT_HI: st_next.lut_hi = reg_wdata[LSD_LUT_BITS-1:0];
				LSD_OFS_CFG: begin
					st_next.cfg      = lsd_cfg_t'(reg_wdata);
					st_next.cfg.rsvd = '0;
				end
				LSD_OFS_CTRL:   st_next.cfg_done = reg_wdata[LSD_DONE_BIT];
				default: ;
			endcase
		end

		st_next.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				LSD_OFS_LUT_LO: st_next.rdata = LSD_DW'(st_reg.lut_lo);
				LSD_OFS_LUT_HI: st_next.rdata = LSD_DW'(st_reg.lut_hi);
				LSD_OFS_CFG:    st_next.rdata = st_reg.cfg;
				LSD_OFS_CTRL:   st_next.rdata = LSD_DW'(st_reg.cfg_done);
				LSD_OFS_STAT:   st_next.rdata = LSD_DW'({st_reg.pins, st_reg.sync2});
				default:        st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= LSD_ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pins_out  = st_reg.pins;
	assign reg_rdata = st_reg.rdata;

	// Checks
	logic hold_ok;
	assign hold_ok = !init_on && !setrst_on && !opp_on && !cap;

	property p_lut_out;
		@(posedge clk_sys) disable iff (!rst_n)
		(c.out_sel_lo == LSD_OUT_LUT) |=> (pins_out.lower_comb_out == $past(lut_lo_val));
	endproperty
	a_lut_out: assert property (p_lut_out) else $error("lower table output wrong");

	property p_sum_out;
		@(posedge clk_sys) disable iff (!rst_n)
		(c.out_sel_hi == LSD_OUT_SUM) |=> (pins_out.upper_comb_out == $past(lut_hi_val ^ cy_lo));
	endproperty
	a_sum_out: assert property (p_sum_out) else $error("upper sum wrong");

	property p_carry;
		@(posedge clk_sys) disable iff (!rst_n)
		(!shift_lo && lut_lo_val) |=> (pins_out.lower_carry_or_shift_out == $past(s.carry_in));
	endproperty
	a_carry: assert property (p_carry) else $error("carry not propagated");

	property p_pair;
		@(posedge clk_sys) disable iff (!rst_n)
		(c.out_sel_lo == LSD_OUT_WIDE && byp_lo)
			|=> (pins_out.lower_comb_out == $past(lut_hi_val));
	endproperty
	a_pair: assert property (p_pair) else $error("pair selector wrong");

	property p_bypass;
		@(posedge clk_sys) disable iff (!rst_n)
		##1 (pins_out.lower_bypass_out == $past(byp_lo)) && (pins_out.upper_bypass_out == $past(byp_hi));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass output wrong");

	property p_init;
		@(posedge clk_sys) disable iff (!rst_n)
		init_on |=> (pins_out.lower_flop_out == $past(c.init_lo))
			&& (pins_out.upper_flop_out == $past(c.init_hi));
	endproperty
	a_init: assert property (p_init) else $error("flop not in initial state");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		hold_ok |=> $stable(pins_out.lower_flop_out) && $stable(pins_out.upper_flop_out);
	endproperty
	a_hold: assert property (p_hold) else $error("flop changed without enable");

	property p_load_byp;
		@(posedge clk_sys) disable iff (!rst_n)
		(cap && !init_on && !setrst_on && !opp_on && c.d_byp_lo)
			|=> (pins_out.lower_flop_out == $past(byp_lo));
	endproperty
	a_load_byp: assert property (p_load_byp) else $error("bypass not loaded");

	property p_opp;
		@(posedge clk_sys) disable iff (!rst_n)
		(opp_on && !init_on && !setrst_on) |=> (pins_out.upper_flop_out == !$past(c.init_hi));
	endproperty
	a_opp: assert property (p_opp) else $error("opposite force missing");

	property p_aux;
		@(posedge clk_sys) disable iff (!rst_n)
		c.aux_en |=> (pins_out.aux_route_out == $past(byp_hi));
	endproperty
	a_aux: assert property (p_aux) else $error("aux route wrong");

	property p_cfg_init;
		@(posedge clk_sys) disable iff (!rst_n)
		!st_reg.cfg_done |=> (pins_out.lower_flop_out == $past(c.init_lo))
			&& (pins_out.upper_flop_out == $past(c.init_hi));
	endproperty
	a_cfg_init: assert property (p_cfg_init) else $error("init not held in config");

	c_capture: cover property (@(posedge clk_sys) disable iff (!rst_n) hold_ok ##1 cap && !init_on);
	c_shift:   cover property (@(posedge clk_sys) disable iff (!rst_n) shift_lo && cap);
	c_ram:     cover property (@(posedge clk_sys) disable iff (!rst_n) ram_hi && clk_edge && s.lut_write_en);
	c_done:    cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(st_reg.cfg_done));

endmodule // lsd_slice

// ==== sim/lsd_icon_model.sv ====
// Purpose: Interconnect stand-in that drives the slice pins and makes slice clock pulses
// Assumes: Requests come from the bench on clk_sys edges
// Notes: Slice clock is high three clk_sys cycles and low at least four, above the two-cycle minimum
`timescale 1ns/10ps
module lsd_icon_model
	import lsd_pkg::*;
(
	input  wire logic    clk_sys,
	input  wire lsd_in_t req,
	input  wire logic    tick,
	output      lsd_in_t pins_in,
	output      logic    busy
);
	logic [2:0] phase_reg = 3'h0;
	always @(posedge clk_sys) begin
		if (tick && phase_reg == 3'h0)
			phase_reg <= 3'h6;
		else if (phase_reg != 3'h0)
			phase_reg <= phase_reg - 3'h1;
	end
	always_comb begin
		pins_in = req;
		// Short pulses could be missed by the sampler, so the high level lasts three cycles and the low level at least four
		pins_in.slice_clk = (phase_reg > 3'h3);
	end
	assign busy = (phase_reg != 3'h0);
endmodule // lsd_icon_model

// ==== sim/lsd_slice_bench.sv ====
// Purpose: Self-checking bench of the slice against a behavioural model
// Assumes: Pin changes reach outputs within four clk_sys edges
// Notes: Flop checks wait until the slice clock pulse has ended
`timescale 1ns/10ps
module lsd_slice_bench
	import lsd_pkg::*;
;
	logic              clk_sys = 1'b0;
	logic              rst_n = 1'b0;
	logic [LSD_AW-1:0] reg_addr = '0;
	logic [LSD_DW-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [LSD_DW-1:0] reg_rdata;
	lsd_in_t           req = '0;
	lsd_in_t           pins_in;
	lsd_out_t          pins_out;
	logic              tick = 1'b0;
	logic              busy;
	int                failures = 0;
	int                check_count = 0;
	logic [31:0]       cfg;
	logic [15:0]       tl;
	logic [15:0]       th;
	logic [7:0]        m;

	always #12.5 clk_sys = ~clk_sys;

	lsd_icon_model icon_u (.clk_sys(clk_sys), .req(req), .tick(tick), .pins_in(pins_in), .busy(busy));
	lsd_slice dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in), .pins_out(pins_out));

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [LSD_AW-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [LSD_AW-1:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		@(negedge clk_sys);
		chk(reg_rdata, e);
	endtask

	task automatic settle;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic pulse;
		@(posedge clk_sys);
		tick <= 1'b1;
		@(posedge clk_sys);
		tick <= 1'b0;
		// Busy rises only behind this edge, so it is looked at from the next one on
		@(posedge clk_sys);
		for (int i = 0; i < 20 && busy; i++)
			@(posedge clk_sys);
		if (busy) begin
			failures++;
			print_verdict();
		end
		settle();
	endtask

	// Unregistered outputs of both halves worked out from the slice equations
	function automatic logic [7:0] model(input logic [31:0] c, input lsd_in_t p);
		logic bl, bh, ll, lh, gl, gh, cl, ch, pr, wd, ol, oh;
		bl = p.lower_bypass_in ^ c[3];
		bh = p.upper_bypass_in ^ c[4];
		ll = tl[p.lower_lut_input];
		lh = th[p.upper_lut_input];
		gl = c[11] ? bl : p.lower_lut_input[0];
		gh = c[12] ? bh : p.upper_lut_input[0];
		cl = ll ? p.carry_in : gl;
		ch = lh ? cl : gh;
		pr = bl ? lh : ll;
		wd = bh ? p.wide_in : pr;
		ol = (c[14:13] == 2'h1) ? (ll ^ p.carry_in) : (c[14:13] == 2'h2) ? pr : ll;
		oh = (c[16:15] == 2'h1) ? (lh ^ cl) : (c[16:15] == 2'h2) ? wd : lh;
		return {ol, oh, cl, ch, bl, bh, c[8] & bh, ch};
	endfunction

	initial begin
		void'($urandom(32'h59c0_032c));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reserved configuration bits and unmapped offsets read as zero
		wr(LSD_OFS_CFG, 32'hFFFF_FFFF);
		rd(LSD_OFS_CFG, 32'h001F_FFFF);
		rd(4'hF, 32'h0000_0000);
		$display("test registers done");
		for (int n = 0; n < 24; n++) begin
			tl = 16'($urandom());
			th = 16'($urandom());
			cfg = $urandom() & 32'h0001_FFFF;
			wr(LSD_OFS_LUT_LO, {16'h0000, tl});
			wr(LSD_OFS_LUT_HI, {16'h0000, th});
			wr(LSD_OFS_CFG, cfg);
			// Slice clock stays low here so the flops are left alone
			req <= lsd_in_t'(17'($urandom()) & 17'h1_FFEF);
			settle();
			m = model(cfg, req);
			chk(32'({pins_out[9:8], pins_out[5:0]}), 32'(m));
			// Done bit is still clear, so both flops sit at their initial values
			rd(LSD_OFS_STAT, 32'({m[7:6], cfg[5], cfg[6], m[5:0], req}));
		end
		$display("test random logic done");
		req <= '0;
		wr(LSD_OFS_CFG, 32'h0000_0200);
		wr(LSD_OFS_CTRL, 32'h0000_0001);
		req.lower_bypass_in <= 1'b1;
		req.slice_ce <= 1'b1;
		pulse();
		chk(32'(pins_out.lower_flop_out), 32'h1);
		req.lower_bypass_in <= 1'b0;
		req.slice_ce <= 1'b0;
		pulse();
		chk(32'(pins_out.lower_flop_out), 32'h1);
		req.slice_ce <= 1'b1;
		pulse();
		chk(32'(pins_out.lower_flop_out), 32'h0);
		req.upper_bypass_in <= 1'b1;
		wr(LSD_OFS_CFG, 32'h0000_0080);
		settle();
		chk(32'({pins_out.lower_flop_out, pins_out.upper_flop_out}), 32'h3);
		req.global_init <= 1'b1;
		settle();
		chk(32'({pins_out.lower_flop_out, pins_out.upper_flop_out}), 32'h0);
		req.global_init <= 1'b0;
		req.upper_bypass_in <= 1'b0;
		wr(LSD_OFS_CFG, 32'h0000_0020);
		wr(LSD_OFS_CTRL, 32'h0000_0000);
		settle();
		chk(32'(pins_out.lower_flop_out), 32'h1);
		wr(LSD_OFS_CFG, 32'h0000_0000);
		wr(LSD_OFS_LUT_LO, 32'h0000_FFFF);
		settle();
		chk(32'(pins_out.lower_flop_out), 32'h0);
		wr(LSD_OFS_CTRL, 32'h0000_0001);
		pulse();
		chk(32'(pins_out.lower_flop_out), 32'h1);
		$display("test flops done");
		// Shift mode on the lower table, bypass as serial data
		wr(LSD_OFS_CFG, 32'h0004_0000);
		wr(LSD_OFS_LUT_LO, 32'h0000_4000);
		req.lower_bypass_in <= 1'b1;
		pulse();
		chk(32'(pins_out.lower_carry_or_shift_out), 32'h1);
		rd(LSD_OFS_LUT_LO, 32'h0000_8001);
		$display("test shift done");
		// RAM mode on the upper table: bypass lands at the addressed bit
		wr(LSD_OFS_CFG, 32'h0008_0000);
		wr(LSD_OFS_LUT_HI, 32'h0000_0000);
		req.upper_lut_input <= 4'h5;
		req.upper_bypass_in <= 1'b1;
		req.lut_write_en <= 1'b1;
		pulse();
		chk(32'(pins_out.upper_comb_out), 32'h1);
		rd(LSD_OFS_LUT_HI, 32'h0000_0020);
		$display("test ram done");
		print_verdict();
	end
endmodule // lsd_slice_bench
